//--- llm_defines.vh
`ifndef LLM_DEFINES_VH
`define LLM_DEFINES_VH

// list geometry
`define LLM_MAX_MODULES    8'h20
`define LLM_MAX_CNT        6'h20
`define LLM_IDX_W          6
`define LLM_WORD_W         16
`define LLM_WADR_W         8

// entry word layout: area selector in upper byte, start address in lower byte
`define LLM_SEL_HI         15
`define LLM_SEL_LO         8
`define LLM_ADR_HI         7
`define LLM_ADR_LO         0

// area selector codes
`define LLM_SEL_AREA_P     8'h00
`define LLM_SEL_AREA_Q     8'h01

// list selector
`define LLM_LIST_IN        1'b0
`define LLM_LIST_OUT       1'b1

// reset values
`define LLM_RST_CNT        6'h00
`define LLM_RST_IDX        6'h00
`define LLM_RST_WADR       8'h00
`define LLM_RST_WORD       16'h0000

`endif

//--- llm_word_fetch.v
`timescale 1ns/1ps
`include "llm_defines.vh"

// fetches one list word from the host data block port or the memory card port
module llm_word_fetch (
    // clock and reset
    input  wire                     clk_i,
    input  wire                     rst_b_i,
    // command from the loader
    input  wire                     go_i,
    input  wire [`LLM_WADR_W-1:0]   addr_i,
    input  wire                     card_sel_i,
    output reg                      done_o,
    output reg  [`LLM_WORD_W-1:0]   data_o,
    // host data block port
    output wire                     db_req_o,
    output wire [`LLM_WADR_W-1:0]   db_addr_o,
    input  wire                     db_ack_i,
    input  wire [`LLM_WORD_W-1:0]   db_data_i,
    // memory card port
    output wire                     card_req_o,
    output wire [`LLM_WADR_W-1:0]   card_addr_o,
    input  wire                     card_ack_i,
    input  wire [`LLM_WORD_W-1:0]   card_data_i
);

    reg                     busy_reg;
    reg                     card_reg;
    reg [`LLM_WADR_W-1:0]   addr_reg;
    wire                    ack;

    // only the selected source sees a request; the other stays quiet
    assign db_req_o    = busy_reg & ~card_reg;
    assign card_req_o  = busy_reg & card_reg;
    assign db_addr_o   = addr_reg;
    assign card_addr_o = addr_reg;
    assign ack         = card_reg ? card_ack_i : db_ack_i;

    // request held until the selected source acknowledges
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            busy_reg <= 1'b0;
            card_reg <= 1'b0;
            addr_reg <= `LLM_RST_WADR;
            done_o   <= 1'b0;
            data_o   <= `LLM_RST_WORD;
        end else begin
            done_o <= 1'b0;
            if (busy_reg && ack) begin
                busy_reg <= 1'b0;
                done_o   <= 1'b1;
                data_o   <= card_reg ? card_data_i : db_data_i;
            end else if (!busy_reg && go_i) begin
                busy_reg <= 1'b1;
                card_reg <= card_sel_i;
                addr_reg <= addr_i;
            end
        end
    end

endmodule

//--- llm_list_mapper.v
`timescale 1ns/1ps
`include "llm_defines.vh"

// How it works
// - after board reset or a host startup pulse the lists are loaded and the first 32 modules of each list are mapped.
// - the list words come either from host data blocks or from the memory card.
// - the first word of each list is the count of entries that follow.
// - entry k after the count belongs to the module at bus location k.
// - each entry has an area selector, 0 for the first area and 1 for the extended area.
// - the entry address is where the module's address range begins.
// - addresses ignore the two configured windows and the module kind.
// - modules and the diagnostic and command registers may sit anywhere in the I/O area.
// - a module may use the same address for its inputs and its outputs.
// - inputs and outputs of a module stay contiguous from their start address.
// - byte-only modules may start on odd byte addresses.
// - inserting or removing modules never shifts the listed addresses.
module llm_list_mapper (
    // clock and reset
    input  wire                     clk_i,
    input  wire                     rst_b_i,
    // startup control
    input  wire                     host_start_i,
    input  wire                     card_sel_i,
    input  wire [`LLM_WADR_W-1:0]   in_list_base_i,
    input  wire [`LLM_WADR_W-1:0]   out_list_base_i,
    // host data block port
    output wire                     db_req_o,
    output wire [`LLM_WADR_W-1:0]   db_addr_o,
    input  wire                     db_ack_i,
    input  wire [`LLM_WORD_W-1:0]   db_data_i,
    // memory card port
    output wire                     card_req_o,
    output wire [`LLM_WADR_W-1:0]   card_addr_o,
    input  wire                     card_ack_i,
    input  wire [`LLM_WORD_W-1:0]   card_data_i,
    // address lookup
    input  wire                     map_req_i,
    input  wire                     map_dir_i,
    input  wire [`LLM_IDX_W-1:0]    map_loc_i,
    input  wire [7:0]               map_offset_i,
    output reg                      map_ack_o,
    output reg                      map_hit_o,
    output reg                      map_area_o,
    output reg  [8:0]               map_addr_o,
    // status
    output wire                     busy_o,
    output reg                      ready_o,
    output reg                      error_o,
    output wire [`LLM_IDX_W-1:0]    in_count_o,
    output wire [`LLM_IDX_W-1:0]    out_count_o
);

    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_COUNT = 2'b01;
    localparam [1:0] ST_ENTRY = 2'b10;

    // entry decode, shared by both lists
    function entry_area;
        input [`LLM_WORD_W-1:0] w;
        begin
            entry_area = (w[`LLM_SEL_HI:`LLM_SEL_LO] == `LLM_SEL_AREA_Q);
        end
    endfunction

    function entry_bad;
        input [`LLM_WORD_W-1:0] w;
        begin
            entry_bad = (w[`LLM_SEL_HI:`LLM_SEL_LO] != `LLM_SEL_AREA_P) &&
                        (w[`LLM_SEL_HI:`LLM_SEL_LO] != `LLM_SEL_AREA_Q);
        end
    endfunction

    // mapping tables, one per direction
    reg                     in_area_mem  [0:31];
    reg [7:0]               in_addr_mem  [0:31];
    reg                     out_area_mem [0:31];
    reg [7:0]               out_addr_mem [0:31];

    reg [1:0]               state_reg,    state_next;
    reg                     list_reg,     list_next;
    reg [`LLM_IDX_W-1:0]    idx_reg,      idx_next;
    reg [`LLM_IDX_W-1:0]    cnt_reg,      cnt_next;
    reg [`LLM_IDX_W-1:0]    in_cnt_reg,   in_cnt_next;
    reg [`LLM_IDX_W-1:0]    out_cnt_reg,  out_cnt_next;
    reg                     ready_next;
    reg                     error_next;
    reg                     start_pend_reg;
    reg                     go_reg,       go_next;
    reg [`LLM_WADR_W-1:0]   wadr_reg,     wadr_next;
    reg                     src_card_reg, src_card_next;
    reg                     wr_en;
    reg                     taking;

    wire                    fetch_done;
    wire [`LLM_WORD_W-1:0]  fetch_data;
    wire [`LLM_WADR_W-1:0]  base;
    wire [8:0]              next_adr_sum;
    wire [7:0]              raw_cnt;

    assign base         = list_reg ? out_list_base_i : in_list_base_i;
    // next word sits right after the previous one, lists have no gaps
    assign next_adr_sum = {1'b0, base} + {3'b000, idx_reg} + 9'h001;
    assign raw_cnt      = fetch_data[7:0];
    assign busy_o       = (state_reg != ST_IDLE);
    assign in_count_o   = in_cnt_reg;
    assign out_count_o  = out_cnt_reg;

    llm_word_fetch u_fetch (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .go_i        (go_reg),
        .addr_i      (wadr_reg),
        .card_sel_i  (src_card_reg),
        .done_o      (fetch_done),
        .data_o      (fetch_data),
        .db_req_o    (db_req_o),
        .db_addr_o   (db_addr_o),
        .db_ack_i    (db_ack_i),
        .db_data_i   (db_data_i),
        .card_req_o  (card_req_o),
        .card_addr_o (card_addr_o),
        .card_ack_i  (card_ack_i),
        .card_data_i (card_data_i)
    );

    // loader sequence: input list count and entries, then output list
    always @* begin
        state_next    = state_reg;
        list_next     = list_reg;
        idx_next      = idx_reg;
        cnt_next      = cnt_reg;
        in_cnt_next   = in_cnt_reg;
        out_cnt_next  = out_cnt_reg;
        ready_next    = ready_o;
        error_next    = error_o;
        go_next       = 1'b0;
        wadr_next     = wadr_reg;
        src_card_next = src_card_reg;
        wr_en         = 1'b0;
        taking        = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_pend_reg) begin
                    taking        = 1'b1;
                    ready_next    = 1'b0;
                    error_next    = 1'b0;
                    src_card_next = card_sel_i;
                    list_next     = `LLM_LIST_IN;
                    idx_next      = `LLM_RST_IDX;
                    wadr_next     = in_list_base_i;
                    go_next       = 1'b1;
                    state_next    = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (fetch_done) begin
                    // count word says how many entries follow
                    if (raw_cnt > `LLM_MAX_MODULES) begin
                        cnt_next   = `LLM_MAX_CNT;
                        error_next = 1'b1;
                    end else begin
                        cnt_next = raw_cnt[`LLM_IDX_W-1:0];
                    end
                    if (list_reg == `LLM_LIST_IN) begin
                        in_cnt_next = cnt_next;
                    end else begin
                        out_cnt_next = cnt_next;
                    end
                    if (cnt_next != `LLM_RST_CNT) begin
                        idx_next   = 6'h01;
                        wadr_next  = next_adr_sum[7:0];
                        go_next    = 1'b1;
                        state_next = ST_ENTRY;
                    end else if (list_reg == `LLM_LIST_IN) begin
                        list_next  = `LLM_LIST_OUT;
                        wadr_next  = out_list_base_i;
                        go_next    = 1'b1;
                    end else begin
                        ready_next = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_ENTRY: begin
                if (fetch_done) begin
                    // entry position alone names the module
                    wr_en = 1'b1;
                    if (entry_bad(fetch_data)) begin
                        error_next = 1'b1;
                    end
                    if (idx_reg != cnt_reg) begin
                        idx_next  = idx_reg + 6'h01;
                        wadr_next = next_adr_sum[7:0];
                        go_next   = 1'b1;
                    end else if (list_reg == `LLM_LIST_IN) begin
                        list_next  = `LLM_LIST_OUT;
                        idx_next   = `LLM_RST_IDX;
                        wadr_next  = out_list_base_i;
                        go_next    = 1'b1;
                        state_next = ST_COUNT;
                    end else begin
                        ready_next = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // control registers; a startup pulse during a load is kept, not lost
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg      <= ST_IDLE;
            list_reg       <= `LLM_LIST_IN;
            idx_reg        <= `LLM_RST_IDX;
            cnt_reg        <= `LLM_RST_CNT;
            in_cnt_reg     <= `LLM_RST_CNT;
            out_cnt_reg    <= `LLM_RST_CNT;
            ready_o        <= 1'b0;
            error_o        <= 1'b0;
            start_pend_reg <= 1'b1;
            go_reg         <= 1'b0;
            wadr_reg       <= `LLM_RST_WADR;
            src_card_reg   <= 1'b0;
        end else begin
            state_reg      <= state_next;
            list_reg       <= list_next;
            idx_reg        <= idx_next;
            cnt_reg        <= cnt_next;
            in_cnt_reg     <= in_cnt_next;
            out_cnt_reg    <= out_cnt_next;
            ready_o        <= ready_next;
            error_o        <= error_next;
            start_pend_reg <= host_start_i | (start_pend_reg & ~taking);
            go_reg         <= go_next;
            wadr_reg       <= wadr_next;
            src_card_reg   <= src_card_next;
        end
    end

    // table write; area comes only from the list, never from module kind
    always @(posedge clk_i) begin
        if (wr_en) begin
            if (list_reg == `LLM_LIST_IN) begin
                in_area_mem[idx_reg[4:0] - 5'h01] <= entry_area(fetch_data);
                in_addr_mem[idx_reg[4:0] - 5'h01] <=
                    fetch_data[`LLM_ADR_HI:`LLM_ADR_LO];
            end else begin
                out_area_mem[idx_reg[4:0] - 5'h01] <= entry_area(fetch_data);
                out_addr_mem[idx_reg[4:0] - 5'h01] <=
                    fetch_data[`LLM_ADR_HI:`LLM_ADR_LO];
            end
        end
    end

    // lookup: location and byte offset to host address
    wire [4:0]              map_slot;
    wire [`LLM_IDX_W-1:0]   map_cnt;
    wire                    map_in_range;
    wire                    sel_area;
    wire [7:0]              sel_start;

    assign map_slot     = map_loc_i[4:0] - 5'h01;
    assign map_cnt      = map_dir_i ? out_cnt_reg : in_cnt_reg;
    // address fixed by list position, no topology shift on insert or removal
    assign map_in_range = (map_loc_i != 6'h00) && (map_loc_i <= map_cnt);
    // input and output tables are independent, so both may hold one address
    assign sel_area     = map_dir_i ? out_area_mem[map_slot] : in_area_mem[map_slot];
    assign sel_start    = map_dir_i ? out_addr_mem[map_slot] : in_addr_mem[map_slot];

    // odd starts pass unchanged; no word alignment is forced
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            map_ack_o  <= 1'b0;
            map_hit_o  <= 1'b0;
            map_area_o <= 1'b0;
            map_addr_o <= 9'h000;
        end else begin
            map_ack_o <= map_req_i;
            if (map_req_i) begin
                map_hit_o  <= ready_o & map_in_range;
                map_area_o <= sel_area;
                map_addr_o <= {1'b0, sel_start} + {1'b0, map_offset_i};
            end
        end
    end

endmodule

//--- llm_list_mapper_chk.sv
`timescale 1ns/1ps
`include "llm_defines.vh"
// lookup, load and source handshake watch on the mapper's ports
module llm_list_mapper_chk (
    // clock and reset
    input wire                   clk_i,
    input wire                   rst_b_i,
    // load side
    input wire                   host_start_i,
    input wire                   db_req_o,
    input wire [`LLM_WADR_W-1:0] db_addr_o,
    input wire                   db_ack_i,
    input wire                   card_req_o,
    input wire                   card_ack_i,
    // lookup side
    input wire                   map_req_i,
    input wire                   map_dir_i,
    input wire [`LLM_IDX_W-1:0]  map_loc_i,
    input wire                   map_ack_o,
    input wire                   map_hit_o,
    input wire                   busy_o,
    input wire                   ready_o,
    input wire [`LLM_IDX_W-1:0]  in_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_ack_one_later: assert property (map_req_i |=> map_ack_o)
        else $error("lookup answer missing");
    a_loc_zero_miss: assert property (map_req_i && map_loc_i == 6'h00 |=> !map_hit_o)
        else $error("location zero hit");
    a_miss_not_ready: assert property (map_req_i && !ready_o && !busy_o |=> !map_hit_o)
        else $error("hit before lists applied");
    a_miss_past_count: assert property (map_req_i && !map_dir_i && !busy_o
        && map_loc_i > in_count_o |=> !map_hit_o) else $error("hit beyond count");
    a_hit_in_count: assert property (map_req_i && !map_dir_i && !busy_o && ready_o
        && map_loc_i != 6'h00 && map_loc_i <= in_count_o |=> map_hit_o || busy_o)
        else $error("listed location missed");
    a_one_source: assert property (!(db_req_o && card_req_o))
        else $error("both sources requested");
    a_req_holds: assert property (db_req_o && !db_ack_i |=> db_req_o && $stable(db_addr_o))
        else $error("word request dropped early");
    a_ready_idle: assert property (ready_o |-> !busy_o)
        else $error("ready while loading");
    a_start_loads: assert property (host_start_i |-> ##[1:2] busy_o)
        else $error("host start ignored");
    a_reset_loads: assert property ($rose(rst_b_i) |-> ##[1:2] busy_o)
        else $error("no load after reset");

    c_hit: cover property (map_ack_o && map_hit_o);
    c_card: cover property (card_req_o && card_ack_i);
    c_full: cover property (ready_o && in_count_o == `LLM_MAX_MODULES);
endmodule

bind llm_list_mapper llm_list_mapper_chk llm_list_mapper_chk_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .host_start_i(host_start_i), .db_req_o(db_req_o),
    .db_addr_o(db_addr_o), .db_ack_i(db_ack_i), .card_req_o(card_req_o),
    .card_ack_i(card_ack_i), .map_req_i(map_req_i), .map_dir_i(map_dir_i),
    .map_loc_i(map_loc_i), .map_ack_o(map_ack_o), .map_hit_o(map_hit_o),
    .busy_o(busy_o), .ready_o(ready_o), .in_count_o(in_count_o));

//--- llm_src_model.sv
`timescale 1ns/1ps
`include "llm_defines.vh"
// list word source: host data block or memory card stand-in
module llm_src_model (
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rst_b_i,
    // read port
    input  wire                   req_i,
    input  wire [`LLM_WADR_W-1:0] addr_i,
    input  wire [3:0]             lat_i,
    output reg                    ack_o,
    output reg  [`LLM_WORD_W-1:0] data_o
);
    reg [`LLM_WORD_W-1:0] mem [0:255];
    reg [3:0]             wait_reg;
    // answer after lat_i cycles; data scrambled outside ack so stale words never pass
    always @(posedge clk_i) begin
        if (!rst_b_i || ack_o) begin
            ack_o    <= 1'b0;
            wait_reg <= 4'h0;
            data_o   <= rst_b_i ? ~data_o : 16'h0000;
        end else if (req_i && wait_reg >= lat_i) begin
            ack_o  <= 1'b1;
            data_o <= mem[addr_i]; // count then entries, back to back
        end else begin
            wait_reg <= req_i ? wait_reg + 4'h1 : wait_reg;
            data_o   <= ~data_o;
        end
    end
endmodule

//--- llm_list_mapper_tb.sv
`timescale 1ns/1ps
`include "llm_defines.vh"
// random lists from both sources, every lookup compared with a table model
module llm_list_mapper_tb;
    reg         clk_i, rst_b_i, host_start_i, card_sel_i, map_req_i, map_dir_i;
    reg  [7:0]  in_list_base_i, out_list_base_i, map_offset_i;
    reg  [5:0]  map_loc_i;
    reg  [3:0]  lat;
    wire        db_req_o, db_ack_i, card_req_o, card_ack_i, map_ack_o, map_hit_o;
    wire        map_area_o, busy_o, ready_o, error_o;
    wire [7:0]  db_addr_o, card_addr_o;
    wire [15:0] db_data_i, card_data_i;
    wire [8:0]  map_addr_o;
    wire [5:0]  in_count_o, out_count_o;
    integer     error_cnt, compares, seed, k, err_exp;
    integer     cnt [0:1];
    integer     sel [0:1][1:32];
    integer     adr [0:1][1:32];

    llm_list_mapper llm_list_mapper_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .host_start_i(host_start_i), .card_sel_i(card_sel_i),
        .in_list_base_i(in_list_base_i), .out_list_base_i(out_list_base_i),
        .db_req_o(db_req_o), .db_addr_o(db_addr_o), .db_ack_i(db_ack_i),
        .db_data_i(db_data_i), .card_req_o(card_req_o), .card_addr_o(card_addr_o),
        .card_ack_i(card_ack_i), .card_data_i(card_data_i), .map_req_i(map_req_i),
        .map_dir_i(map_dir_i), .map_loc_i(map_loc_i), .map_offset_i(map_offset_i),
        .map_ack_o(map_ack_o), .map_hit_o(map_hit_o), .map_area_o(map_area_o),
        .map_addr_o(map_addr_o), .busy_o(busy_o), .ready_o(ready_o),
        .error_o(error_o), .in_count_o(in_count_o), .out_count_o(out_count_o));
    llm_src_model db_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(db_req_o),
        .addr_i(db_addr_o), .lat_i(lat), .ack_o(db_ack_i), .data_o(db_data_i));
    llm_src_model card_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(card_req_o),
        .addr_i(card_addr_o), .lat_i(lat), .ack_o(card_ack_i), .data_o(card_data_i));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function integer rnd(input integer lim);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = (seed & 32'h7fff_ffff) % lim;
        end
    endfunction

    task check(input bit ok, input string msg);
        begin
            compares = compares + 1;
            if (!ok) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t %s", $time, msg);
            end
        end
    endtask

    task put(input integer src, input integer a, input integer v);
        if (src) card_model.mem[a] = v[15:0];
        else db_model.mem[a] = v[15:0];
    endtask

    // builds both lists; out entries at even locations up to nin reuse the input address
    task fill(input integer src, input integer nin, input integer nout);
        integer l, j, c, b, s, w, bi, bo;
        begin
            err_exp = 0;
            bi = rnd(96);
            bo = 128 + rnd(90);
            @(posedge clk_i);
            in_list_base_i  <= bi[7:0];
            out_list_base_i <= bo[7:0];
            for (l = 0; l < 2; l = l + 1) begin
                c = l ? nout : nin;
                b = l ? bo : bi;
                cnt[l] = c > 32 ? 32 : c;
                err_exp = err_exp | (c > 32);
                put(src, b, c); // count word first
                for (j = 1; j <= c; j = j + 1) begin
                    s = rnd(8) == 0 ? 2 : rnd(2);
                    w = (l && j % 2 == 0 && j <= nin) ? adr[0][j] : rnd(256);
                    if (j % 4 == 0) w = w & 254; // word modules get even starts
                    if (j <= 32) begin
                        sel[l][j] = s;
                        adr[l][j] = w;
                        err_exp = err_exp | (s > 1);
                    end
                    put(src, b + j, s * 256 + w);
                end
            end
        end
    endtask

    task look(input integer dir, input integer loc);
        integer off, hit, ex;
        begin
            off = rnd(256);
            hit = loc >= 1 && loc <= cnt[dir];
            @(posedge clk_i);
            map_req_i    <= 1'b1;
            map_dir_i    <= dir[0];
            map_loc_i    <= loc[5:0];
            map_offset_i <= off[7:0];
            @(posedge clk_i);
            #1;
            check(map_ack_o === 1'b1 && map_hit_o === hit[0], "lookup hit");
            if (hit) begin
                ex = adr[dir][loc] + off;
                check(map_area_o === (sel[dir][loc] == 1), "area");
                check(map_addr_o === ex[8:0], "address");
            end
        end
    endtask

    // mode 0: reset startup, 1: host start, 2: host start cut by a reset
    task load(input integer src, input integer nin, input integer nout, input integer mode);
        integer r;
        begin
            fill(src, nin, nout);
            r = rnd(10);
            lat        <= r[3:0];
            card_sel_i <= src[0];
            if (mode == 0) begin
                repeat (5) @(posedge clk_i);
                rst_b_i <= 1'b1;
            end else begin
                host_start_i <= 1'b1;
                @(posedge clk_i);
                host_start_i <= 1'b0;
            end
            if (mode == 2) begin
                repeat (8) @(posedge clk_i);
                rst_b_i <= 1'b0;
                repeat (2) @(posedge clk_i);
                rst_b_i <= 1'b1;
                #1;
                check(ready_o === 1'b0 && busy_o === 1'b0, "reset state");
            end
            repeat (3) @(posedge clk_i);
            #1;
            for (k = 0; k < 3000 && !(ready_o === 1'b1 && busy_o === 1'b0); k = k + 1) begin
                @(posedge clk_i);
                #1;
            end
            check(ready_o === 1'b1 && busy_o === 1'b0, "load end");
            check(in_count_o === cnt[0][5:0] && out_count_o === cnt[1][5:0], "counts");
            check(error_o === err_exp[0], "error flag");
            for (k = 0; k < 68; k = k + 1)
                look(k / 34, k % 34);
        end
    endtask

    task close_out;
        begin
            if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    // watchdog far beyond the few thousand cycles expected
    initial begin
        #1_000_000;
        error_cnt = error_cnt + 1;
        $display("ERROR %0t watchdog expired", $time);
        close_out;
    end

    // startup from data blocks, then card, shorter list and a cut load
    initial begin
        {rst_b_i, host_start_i, card_sel_i, map_req_i, map_dir_i, lat} = 9'h000;
        {in_list_base_i, out_list_base_i, map_offset_i, map_loc_i} = 30'h0000_0000;
        seed = 79099;
        error_cnt = 0;
        compares = 0;
        load(0, 13, 13, 0);
        load(1, 32, 33, 1);
        load(0, 5, 0, 1);
        load(1, 7, 4, 2);
        close_out;
    end
endmodule
